/* rtl/irq_port_pkg.sv */
// Purpose: shared constants and helpers for the interrupt port block
// Assumes: 32-bit slave data, one clock domain
// Notes: widths and counts are fixed configuration values
package irq_port_pkg;

  // =====================================================================
  // configuration
  localparam int NUM_CORES = 3;
  localparam int CORE_W = 2;
  localparam int PPI_CFG = 16;
  localparam int SPI_WIRES = 32;
  localparam int SPI_SUPPORTED = 64;
  localparam int MSG_W = 16;
  localparam int PPI_ID_W = 5;
  localparam logic WIDE_MESSAGE_OPTION = 1'b0;

  // =====================================================================
  // slave port layout
  localparam int AXI_ADDR_W = 16;
  localparam int AXI_ID_W = 4;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  localparam int DEVID_W = 8;
  localparam logic [AXI_ADDR_W-1:0] TRANS_OFF = 16'h0040;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] BURST_FIXED = 2'h0;

  // =====================================================================
  // reset values
  localparam logic [AXI_DATA_W-1:0] TRANS_RESET = 32'h0000_0000;
  localparam logic [MSG_W-1:0] MSG_RESET = 16'h0000;

  // interrupt number carried by a private slot for the configured count
  function automatic logic [PPI_ID_W-1:0] ppi_id(input int slot);
    int n;
    n = 0;
    if (PPI_CFG == 16)
    begin
      n = 16 + slot;
    end
    else if (PPI_CFG == 12)
    begin
      n = 20 + slot;
    end
    else if (slot < 6)
    begin
      n = 22 + slot;
    end
    else
    begin
      n = (slot == 6) ? 29 : 30;
    end
    return PPI_ID_W'(n);
  endfunction : ppi_id

  function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] a);
    return a[AXI_ADDR_W-1:2] == TRANS_OFF[AXI_ADDR_W-1:2];
  endfunction : addr_hit

  function automatic logic [1:0] beat_resp(input logic [AXI_ADDR_W-1:0] a);
    return addr_hit(a) ? RESP_OKAY : RESP_SLVERR;
  endfunction : beat_resp

  // wrap bursts advance as incrementing ones
  function automatic logic [AXI_ADDR_W-1:0] next_addr(
    input logic [AXI_ADDR_W-1:0] a,
    input logic [2:0] size,
    input logic [1:0] burst
  );
    logic [AXI_ADDR_W-1:0] step;
    step = AXI_ADDR_W'(1) << size;
    return (burst == BURST_FIXED) ? a : AXI_ADDR_W'(a + step);
  endfunction : next_addr

endpackage : irq_port_pkg

/* rtl/cond_if.sv */
// Purpose: carries raw interrupt wires and their conditioned forms
// Assumes: single clock domain
// Notes: one instance per bank of wires
`timescale 1ns/100ps
interface cond_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport bank (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface : cond_if

/* rtl/intr_cond_bank.sv */
// Purpose: two-stage synchroniser plus edge detector for a wire bank
// Assumes: ce freezes all state
// Notes: level is registered, rise is a one-cycle pulse
`timescale 1ns/100ps
module intr_cond_bank #(parameter int W = 1) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  cond_if.bank c
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // =====================================================================
  // synchroniser and edge detect
  always_comb
  begin
    meta_next = c.raw;
    sync_next = meta_reg;
    level_next = sync_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      level_reg <= '0;
    end
    else if (ce)
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  assign c.level = level_reg;
  assign c.rise = sync_reg & ~level_reg;

endmodule : intr_cond_bank

/* rtl/irq_port_top.sv */
// Purpose: external ports of an interrupt controller
// Assumes: all inputs synchronous to sys_clk, ce freezes state
// Notes: private edges and translation writes become outbound messages
`timescale 1ns/100ps
module irq_port_top
  import irq_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [NUM_CORES-1:0][PPI_CFG-1:0] ppi_in,
  output logic [NUM_CORES-1:0][PPI_CFG-1:0] ppi_r,
  input wire logic [SPI_WIRES-1:0] spi_in,
  output logic [SPI_WIRES-1:0] spi_r,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [MSG_W-1:0] in_data,
  input wire logic [CORE_W-1:0] in_src,
  input wire logic in_last,
  input wire logic in_wake,
  output logic in_msg_valid,
  output logic [MSG_W-1:0] in_msg_data,
  output logic [CORE_W-1:0] in_msg_src,
  output logic in_msg_last,
  output logic core_wake_seen,
  output logic out_valid,
  input wire logic out_ready,
  output logic [MSG_W-1:0] out_data,
  output logic [CORE_W-1:0] out_dest,
  output logic out_last,
  output logic out_wake,
  output logic [DEVID_W-1:0] requester_device_id,
  input wire logic [AXI_ID_W-1:0] awid,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic [DEVID_W-1:0] awuser,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [AXI_STRB_W-1:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  output logic wready,
  output logic [AXI_ID_W-1:0] bid,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ID_W-1:0] arid,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic [2:0] arsize,
  input wire logic [1:0] arburst,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_ID_W-1:0] rid,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic rvalid,
  input wire logic rready
);

  localparam int PPI_W = NUM_CORES * PPI_CFG;

  typedef enum logic [1:0] {AX_IDLE, AX_WDATA, AX_WRESP, AX_RDATA} ax_state_t;

  // =====================================================================
  // conditioning banks
  cond_if #(.W(PPI_W)) ppi_c ();
  cond_if #(.W(SPI_WIRES)) spi_c ();

  assign ppi_c.raw = ppi_in;
  assign spi_c.raw = spi_in;

  intr_cond_bank #(.W(PPI_W)) u_ppi_bank (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .c(ppi_c.bank)
  );

  intr_cond_bank #(.W(SPI_WIRES)) u_spi_bank (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .c(spi_c.bank)
  );

  assign ppi_r = ppi_c.level;
  assign spi_r = spi_c.level;

  // lowest pending slot wins
  function automatic int first_set(input logic [PPI_W-1:0] v);
    int r;
    r = 0;
    for (int i = PPI_W - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = i;
      end
    end
    return r;
  endfunction : first_set

  // =====================================================================
  // slave port state
  ax_state_t ax_state_reg, ax_state_next;
  logic turn_reg, turn_next;
  logic awready_reg, awready_next;
  logic arready_reg, arready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [AXI_ID_W-1:0] bid_reg, bid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic rlast_reg, rlast_next;
  logic [AXI_ID_W-1:0] rid_reg, rid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [AXI_DATA_W-1:0] rdata_reg, rdata_next;
  logic [AXI_ADDR_W-1:0] addr_reg, addr_next;
  logic [AXI_ID_W-1:0] id_reg, id_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] size_reg, size_next;
  logic [1:0] burst_reg, burst_next;
  logic [DEVID_W-1:0] user_reg, user_next;
  logic err_reg, err_next;
  logic [AXI_DATA_W-1:0] message_translation_reg, trans_word_next;
  logic trans_fire;
  logic [AXI_ADDR_W-1:0] a_step;

  always_comb
  begin
    ax_state_next = ax_state_reg;
    turn_next = turn_reg;
    wready_next = wready_reg;
    bvalid_next = bvalid_reg;
    bid_next = bid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rlast_next = rlast_reg;
    rid_next = rid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    addr_next = addr_reg;
    id_next = id_reg;
    cnt_next = cnt_reg;
    size_next = size_reg;
    burst_next = burst_reg;
    user_next = user_reg;
    err_next = err_reg;
    trans_word_next = message_translation_reg;
    trans_fire = 1'b0;
    a_step = next_addr(addr_reg, size_reg, burst_reg);
    unique case (ax_state_reg)
      AX_IDLE:
      begin
        if (awvalid && awready_reg)
        begin
          id_next = awid;
          addr_next = awaddr;
          size_next = awsize;
          burst_next = awburst;
          user_next = awuser;
          err_next = 1'b0;
          wready_next = 1'b1;
          ax_state_next = AX_WDATA;
        end
        else if (arvalid && arready_reg)
        begin
          addr_next = araddr;
          size_next = arsize;
          burst_next = arburst;
          cnt_next = arlen;
          rvalid_next = 1'b1;
          rid_next = arid;
          rresp_next = beat_resp(araddr);
          rdata_next = addr_hit(araddr) ? message_translation_reg : '0;
          rlast_next = (arlen == 8'h00);
          ax_state_next = AX_RDATA;
        end
        else
        begin
          turn_next = ~turn_reg;
        end
      end
      AX_WDATA:
      begin
        if (wvalid && wready_reg)
        begin
          if (addr_hit(addr_reg))
          begin
            for (int b = 0; b < AXI_STRB_W; b++)
            begin
              if (wstrb[b])
              begin
                trans_word_next[8*b +: 8] = wdata[8*b +: 8];
              end
            end
          end
          err_next = err_reg | ~addr_hit(addr_reg);
          addr_next = a_step;
          if (wlast)
          begin
            wready_next = 1'b0;
            bvalid_next = 1'b1;
            bid_next = id_reg;
            bresp_next = err_next ? RESP_SLVERR : RESP_OKAY;
            trans_fire = ~err_next;
            ax_state_next = AX_WRESP;
          end
        end
      end
      AX_WRESP:
      begin
        if (bready)
        begin
          bvalid_next = 1'b0;
          ax_state_next = AX_IDLE;
        end
      end
      AX_RDATA:
      begin
        if (rready)
        begin
          if (rlast_reg)
          begin
            rvalid_next = 1'b0;
            rlast_next = 1'b0;
            ax_state_next = AX_IDLE;
          end
          else
          begin
            addr_next = a_step;
            cnt_next = cnt_reg - 8'h01;
            rresp_next = beat_resp(a_step);
            rdata_next = addr_hit(a_step) ? message_translation_reg : '0;
            rlast_next = (cnt_next == 8'h00);
          end
        end
      end
    endcase
    awready_next = (ax_state_next == AX_IDLE) && !turn_next;
    arready_next = (ax_state_next == AX_IDLE) && turn_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ax_state_reg <= AX_IDLE;
      turn_reg <= 1'b0;
      awready_reg <= 1'b0;
      arready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bid_reg <= '0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rlast_reg <= 1'b0;
      rid_reg <= '0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      addr_reg <= '0;
      id_reg <= '0;
      cnt_reg <= '0;
      size_reg <= '0;
      burst_reg <= BURST_FIXED;
      user_reg <= '0;
      err_reg <= 1'b0;
      message_translation_reg <= TRANS_RESET;
    end
    else if (ce)
    begin
      ax_state_reg <= ax_state_next;
      turn_reg <= turn_next;
      awready_reg <= awready_next;
      arready_reg <= arready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bid_reg <= bid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rlast_reg <= rlast_next;
      rid_reg <= rid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      addr_reg <= addr_next;
      id_reg <= id_next;
      cnt_reg <= cnt_next;
      size_reg <= size_next;
      burst_reg <= burst_next;
      user_reg <= user_next;
      err_reg <= err_next;
      message_translation_reg <= trans_word_next;
    end
  end

  // =====================================================================
  // streams
  logic [PPI_W-1:0] pend_reg, pend_next;
  logic tpend_reg, tpend_next;
  logic [MSG_W-1:0] tdata_reg, tdata_next;
  logic [DEVID_W-1:0] devid_reg, devid_next;
  logic out_valid_reg, out_valid_next;
  logic [MSG_W-1:0] out_data_reg, out_data_next;
  logic [CORE_W-1:0] out_dest_reg, out_dest_next;
  logic out_wake_reg, out_wake_next;
  logic in_ready_reg;
  logic in_msg_valid_reg, in_msg_valid_next;
  logic [MSG_W-1:0] in_data_reg, in_data_next;
  logic [CORE_W-1:0] in_src_reg, in_src_next;
  logic in_last_reg, in_last_next;
  logic wake_seen_reg;
  int sel;

  always_comb
  begin
    sel = first_set(pend_reg);
    pend_next = pend_reg;
    tpend_next = tpend_reg;
    tdata_next = tdata_reg;
    devid_next = devid_reg;
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    out_dest_next = out_dest_reg;
    if (out_valid_reg && out_ready)
    begin
      out_valid_next = 1'b0;
    end
    if (!out_valid_next)
    begin
      if (|pend_reg)
      begin
        out_valid_next = 1'b1;
        out_data_next = MSG_W'(ppi_id(sel % PPI_CFG));
        out_dest_next = CORE_W'(sel / PPI_CFG);
        pend_next[sel] = 1'b0;
      end
      else if (tpend_reg)
      begin
        out_valid_next = 1'b1;
        out_data_next = tdata_reg;
        out_dest_next = '0;
        tpend_next = 1'b0;
      end
    end
    // new edges win over the clear of a sent slot
    pend_next = pend_next | ppi_c.rise;
    if (trans_fire)
    begin
      tpend_next = 1'b1;
      tdata_next = trans_word_next[MSG_W-1:0];
      devid_next = WIDE_MESSAGE_OPTION ? '0 : user_reg;
    end
    out_wake_next = |pend_next | tpend_next | out_valid_next;
    in_msg_valid_next = in_valid && in_ready_reg;
    in_data_next = in_data_reg;
    in_src_next = in_src_reg;
    in_last_next = in_last_reg;
    if (in_valid && in_ready_reg)
    begin
      in_data_next = in_data;
      in_src_next = in_src;
      in_last_next = in_last;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pend_reg <= '0;
      tpend_reg <= 1'b0;
      tdata_reg <= MSG_RESET;
      devid_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= MSG_RESET;
      out_dest_reg <= '0;
      out_wake_reg <= 1'b0;
      in_ready_reg <= 1'b0;
      in_msg_valid_reg <= 1'b0;
      in_data_reg <= MSG_RESET;
      in_src_reg <= '0;
      in_last_reg <= 1'b0;
      wake_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      pend_reg <= pend_next;
      tpend_reg <= tpend_next;
      tdata_reg <= tdata_next;
      devid_reg <= devid_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      out_dest_reg <= out_dest_next;
      out_wake_reg <= out_wake_next;
      in_ready_reg <= 1'b1;
      in_msg_valid_reg <= in_msg_valid_next;
      in_data_reg <= in_data_next;
      in_src_reg <= in_src_next;
      in_last_reg <= in_last_next;
      wake_seen_reg <= in_wake;
    end
  end

  assign in_ready = in_ready_reg;
  assign in_msg_valid = in_msg_valid_reg;
  assign in_msg_data = in_data_reg;
  assign in_msg_src = in_src_reg;
  assign in_msg_last = in_last_reg;
  assign core_wake_seen = wake_seen_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_dest = out_dest_reg;
  assign out_last = out_valid_reg;
  assign out_wake = out_wake_reg;
  assign requester_device_id = devid_reg;
  assign awready = awready_reg;
  assign arready = arready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bid = bid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rlast = rlast_reg;
  assign rid = rid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !ce);

  sequence s_wlast_beat;
    wvalid && wready_reg && wlast;
  endsequence
  sequence s_hit_end;
    s_wlast_beat and (!err_next);
  endsequence

  property p_dest_range;
    out_valid_reg |-> (out_dest_reg < CORE_W'(NUM_CORES));
  endproperty
  a_dest_range: assert property (p_dest_range)
    else $error("outbound destination out of range");

  property p_out_hold;
    out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_data_reg);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("outbound message dropped while stalled");

  property p_rise_pends;
    ppi_c.rise[0] |=> pend_reg[0] || (out_valid_reg && out_dest_reg == '0
      && out_data_reg == MSG_W'(ppi_id(0)));
  endproperty
  a_rise_pends: assert property (p_rise_pends)
    else $error("private edge lost");

  property p_wake;
    out_valid_reg |-> out_wake_reg;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake hint low with message present");

  property p_bresp_hold;
    bvalid_reg && !bready |=> bvalid_reg && $stable(bid_reg)
      && $stable(bresp_reg);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response not held");

  property p_single_read;
    arvalid && arready_reg && arlen == 8'h00 |=> rvalid_reg && rlast_reg
      && rid_reg == $past(arid);
  endproperty
  a_single_read: assert property (p_single_read)
    else $error("single beat read wrong");

  property p_write_end;
    s_wlast_beat |=> (bvalid_reg && !wready_reg && !awready_reg
      && !arready_reg) ##1 (bvalid_reg || awready_reg || arready_reg);
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write burst end not answered");

  property p_devid;
    s_hit_end |=> tpend_reg && devid_reg == $past(user_reg);
  endproperty
  a_devid: assert property (p_devid)
    else $error("device id not captured");

  property p_in_ready;
    $past(rst_b) |-> in_ready_reg;
  endproperty
  a_in_ready: assert property (p_in_ready)
    else $error("inbound stream back-pressured");

endmodule : irq_port_top

/* dv/core_blk_model.sv */
// Purpose: core block model on both message streams
// Assumes: driven at the falling edge
// Notes: outbound sink stalls one cycle in four
`timescale 1ns/100ps
module core_blk_model
  import irq_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [MSG_W-1:0] in_data,
  output logic [CORE_W-1:0] in_src,
  output logic in_last,
  output logic in_wake,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [MSG_W-1:0] out_data,
  input wire logic [CORE_W-1:0] out_dest,
  input wire logic out_last,
  input wire logic out_wake
);
  // ==================================================================
  // outbound sink
  logic [19:0] got_q[$];
  logic [1:0] stall_reg = 2'h0;
  initial
  begin
    {in_valid, in_data, in_src, in_last, in_wake} = '0;
    out_ready = 1'b0;
  end
  always @(negedge sys_clk)
  begin
    stall_reg <= stall_reg + 2'h1;
    out_ready <= (stall_reg != 2'h3);
  end
  always @(posedge sys_clk)
    if (out_valid && out_ready)
      got_q.push_back({out_wake, out_last, out_dest, out_data});
  // ==================================================================
  // inbound source: wake one cycle ahead, held to handshake
  task automatic send(input logic [MSG_W-1:0] d, input int src,
    input logic l);
    @(negedge sys_clk);
    in_wake = 1'b1;
    @(negedge sys_clk);
    in_valid = 1'b1;
    in_data = d;
    in_src = CORE_W'(src);
    in_last = l;
    do @(posedge sys_clk); while (in_ready !== 1'b1);
    @(negedge sys_clk);
    in_valid = 1'b0;
    in_wake = 1'b0;
    in_data = ~d;
  endtask : send
endmodule : core_blk_model

/* dv/tb_top.sv */
// Purpose: self-checking bench for the interrupt port block
// Assumes: single outstanding slave access
// Notes: expected messages queued in order of issue
`timescale 1ns/100ps
module tb_top
  import irq_port_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic [NUM_CORES-1:0][PPI_CFG-1:0] ppi_in = '0, ppi_r;
  logic [SPI_WIRES-1:0] spi_in = '0, spi_r;
  logic in_valid, in_ready, in_last, in_wake, in_msg_valid, in_msg_last;
  logic [MSG_W-1:0] in_data, in_msg_data, out_data;
  logic [CORE_W-1:0] in_src, in_msg_src, out_dest;
  logic core_wake_seen, out_valid, out_ready, out_last, out_wake;
  logic [DEVID_W-1:0] requester_device_id, awuser = '0, exp_dev = '0;
  logic [AXI_ID_W-1:0] awid = '0, arid = '0, bid, rid;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [7:0] awlen = '0, arlen = '0;
  logic [2:0] awsize = 3'h2, arsize = 3'h2;
  logic [1:0] awburst = 2'h1, arburst = 2'h1, bresp, rresp;
  logic awvalid = 1'b0, awready, wlast = 1'b0, wvalid = 1'b0, wready;
  logic bvalid, bready = 1'b0, arvalid = 1'b0, arready;
  logic rlast, rvalid, rready = 1'b0;
  logic [AXI_DATA_W-1:0] wdata = '0, rdata, word = TRANS_RESET;
  logic [AXI_STRB_W-1:0] wstrb = '0;
  logic [19:0] exp_q[$];
  int errors = 0, num_checks = 0, seed = 32'h0f95;
  always #2.5 sys_clk = ~sys_clk;
  irq_port_top u_dut (.sys_clk, .rst_b, .ce, .ppi_in, .ppi_r, .spi_in,
    .spi_r, .in_valid, .in_ready, .in_data, .in_src, .in_last, .in_wake,
    .in_msg_valid, .in_msg_data, .in_msg_src, .in_msg_last,
    .core_wake_seen, .out_valid, .out_ready, .out_data, .out_dest,
    .out_last, .out_wake, .requester_device_id, .awid, .awaddr, .awlen,
    .awsize, .awburst, .awuser, .awvalid, .awready, .wdata, .wstrb,
    .wlast, .wvalid, .wready, .bid, .bresp, .bvalid, .bready, .arid,
    .araddr, .arlen, .arsize, .arburst, .arvalid, .arready, .rid, .rdata,
    .rresp, .rlast, .rvalid, .rready);
  core_blk_model u_core (.sys_clk, .in_ready, .in_valid, .in_data,
    .in_src, .in_last, .in_wake, .out_valid, .out_ready, .out_data,
    .out_dest, .out_last, .out_wake);
  // ==================================================================
  // compares and closing
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_msg();
    logic [19:0] g;
    g = '1;
    repeat (200)
      if (u_core.got_q.size() == 0)
        @(negedge sys_clk);
    if (u_core.got_q.size() != 0)
      g = u_core.got_q.pop_front();
    chk_val(64'(g), 64'(exp_q.pop_front()));
  endtask : chk_msg
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ==================================================================
  // slave port master
  task automatic axi_wr(input logic [15:0] a, input logic [1:0] bt,
    input int beats);
    logic ok;
    ok = (a[15:2] == TRANS_OFF[15:2]);
    @(negedge sys_clk);
    awaddr = a;
    awburst = bt;
    awlen = 8'(beats - 1);
    awid = 4'($random(seed));
    awuser = 8'($random(seed));
    awvalid = 1'b1;
    do @(posedge sys_clk); while (awready !== 1'b1);
    @(negedge sys_clk);
    awvalid = 1'b0;
    for (int i = 0; i < beats; i++)
    begin
      wvalid = 1'b1;
      wdata = $random(seed);
      wstrb = 4'($random(seed));
      wlast = (i == beats - 1);
      do @(posedge sys_clk); while (wready !== 1'b1);
      for (int b = 0; b < 4; b++)
        if (ok && wstrb[b])
          word[8*b+:8] = wdata[8*b+:8];
      @(negedge sys_clk);
    end
    wvalid = 1'b0;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    @(negedge sys_clk);
    bready = 1'b1;
    @(posedge sys_clk);
    chk_val({bid, bresp}, {awid, ok ? RESP_OKAY : RESP_SLVERR});
    @(negedge sys_clk);
    bready = 1'b0;
    if (ok)
    begin
      exp_q.push_back({2'h3, 2'h0, word[15:0]});
      exp_dev = awuser;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, input logic [1:0] bt,
    input int beats);
    logic ok;
    @(negedge sys_clk);
    araddr = a;
    arburst = bt;
    arlen = 8'(beats - 1);
    arid = 4'($random(seed));
    arvalid = 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    @(negedge sys_clk);
    arvalid = 1'b0;
    rready = 1'b1;
    for (int i = 0; i < beats; i++)
    begin
      ok = (a[15:2] == TRANS_OFF[15:2]);
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      chk_val({rid, rresp, rlast, rdata}, {arid, ok ? RESP_OKAY :
        RESP_SLVERR, i == beats - 1, ok ? word : 32'h0});
      a = (bt == BURST_FIXED) ? a : a + 16'h4;
    end
    @(negedge sys_clk);
    rready = 1'b0;
  endtask : axi_rd
  // ==================================================================
  // main sequence
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
  initial
  begin
    int s;
    logic [15:0] d;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    chk_val({in_ready, awready, arready, out_valid}, 4'ha);
    for (int c = 0; c < NUM_CORES; c++)
    begin
      s = $unsigned($random(seed)) % PPI_CFG;
      ppi_in[c][s] = 1'b1;
      exp_q.push_back({2'h3, 2'(c), 16'(16 + s)});
      chk_msg();
      chk_val(64'(ppi_r), 64'(ppi_in));
      ppi_in[c][s] = 1'b0;
    end
    @(negedge sys_clk);
    ppi_in[2][5] = 1'b1;
    ppi_in[1][9] = 1'b1;
    ppi_in[0][0] = 1'b1;
    exp_q.push_back({2'h3, 2'h0, 16'd16});
    exp_q.push_back({2'h3, 2'h1, 16'd25});
    exp_q.push_back({2'h3, 2'h2, 16'd21});
    chk_msg();
    chk_msg();
    chk_msg();
    ppi_in = '0;
    repeat (4)
    begin
      spi_in = $random(seed);
      repeat (4) @(negedge sys_clk);
      chk_val(64'(spi_r), 64'(spi_in));
    end
    // clock enable low: conditioning frozen
    ce = 1'b0;
    ppi_in[0][3] = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk_val(64'(ppi_r), 64'h0);
    ce = 1'b1;
    exp_q.push_back({2'h3, 2'h0, 16'd19});
    chk_msg();
    ppi_in = '0;
    repeat (4)
    begin
      d = 16'($random(seed));
      s = $unsigned($random(seed)) % NUM_CORES;
      u_core.send(d, s, d[0]);
      chk_val({in_msg_valid, in_msg_data, in_msg_src, in_msg_last,
        core_wake_seen}, {1'b1, d, 2'(s), d[0], 1'b1});
    end
    axi_wr(16'h0040, 2'h1, 1);
    chk_msg();
    chk_val(requester_device_id, exp_dev);
    axi_wr(16'h0040, BURST_FIXED, 3);
    chk_msg();
    axi_wr(16'h0080, 2'h1, 1);
    chk_val(requester_device_id, exp_dev);
    axi_rd(16'h0040, BURST_FIXED, 2);
    axi_rd(16'h0040, 2'h1, 2);
    axi_rd(16'h0100, 2'h1, 1);
    // mid-run reset clears the translation word
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    word = TRANS_RESET;
    @(negedge sys_clk);
    chk_val({in_ready, awready, arready, out_valid}, 4'ha);
    axi_rd(16'h0040, 2'h1, 1);
    repeat (20) @(negedge sys_clk);
    chk_val(u_core.got_q.size(), 0);
    complete_run();
  end
endmodule : tb_top
